// ==== design/uesr_regs.sv ====
// register bank for endpoints one to seven of a usb device controller, axi4-lite slave
// assumes engine status and event pulses are synchronous to aclk
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
module uesr_regs (
    input  wire logic                               aclk,
    input  wire logic                               aresetn,
    // axi4-lite slave
    input  wire logic [7:0]                         s_awaddr,
    input  wire logic                               s_awvalid,
    output logic                                    s_awready,
    input  wire logic [31:0]                        s_wdata,
    input  wire logic [3:0]                         s_wstrb,
    input  wire logic                               s_wvalid,
    output logic                                    s_wready,
    output logic [1:0]                              s_bresp,
    output logic                                    s_bvalid,
    input  wire logic                               s_bready,
    input  wire logic [7:0]                         s_araddr,
    input  wire logic                               s_arvalid,
    output logic                                    s_arready,
    output logic [31:0]                             s_rdata,
    output logic [1:0]                              s_rresp,
    output logic                                    s_rvalid,
    input  wire logic                               s_rready,
    // engine side, one entry per endpoint except the shared fifo_wr_data and irq
    input  wire uesr_pkg::uesr_eng_t [6:0]          eng_status,
    input  wire uesr_pkg::uesr_evt_t [6:0]          eng_event,
    input  wire logic [6:0][15:0]                   fifo_rd_data,
    output uesr_pkg::uesr_cfg_t [6:0]               ep_cfg,
    output logic [6:0][2:0]                         ep_state,
    output logic [6:0]                              fifo_wr,
    output logic [6:0]                              fifo_rd,
    output logic [15:0]                             fifo_wr_data,
    output logic                                    irq
);
    // bus holding registers
    logic [7:0]  awaddr_q;              // captured write address
    logic        aw_have_q;             // address taken, waiting data
    logic [31:0] wdata_q;               // captured write data
    logic [3:0]  wstrb_q;
    logic        w_have_q;              // data taken, waiting address
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    // register state
    uesr_pkg::uesr_cfg_t [6:0] cfg_q;   // per-endpoint config
    logic [6:0][2:0]           state_q; // per-endpoint state
    logic [6:0]                ists_q;  // sticky error events
    logic [6:0]                imsk_q;  // interrupt mask, a one hides that status bit
    logic                      irq_q;
    logic [6:0]                fwr_q;   // one-cycle data port write strobes
    logic [6:0]                frd_q;   // one-cycle data port read strobes
    logic [15:0]               fwd_q;

    // write fires once both halves are present
    logic        wr_go;
    logic [7:0]  wa;
    logic [31:0] wd;
    logic        wr_hit_ep;
    logic [2:0]  wr_ep;                 // zero-based endpoint index
    logic [7:0]  wr_off;
    logic        rd_go;
    logic [2:0]  rd_ep;                 // zero-based endpoint index of the read address

    assign wr_go  = aw_have_q && w_have_q && !bvalid_q;
    assign wa     = awaddr_q;
    assign wd     = wdata_q;
    assign wr_ep  = 3'(wa[7:4]);
    assign wr_off = {4'h0, wa[3:0]};
    // endpoint blocks at 0x00..0x6c, one stride per endpoint
    assign wr_hit_ep = (wa[7:4] < 4'(uesr_pkg::NUM_EP)) && (wa[1:0] == 2'h0);
    assign rd_go  = s_arvalid && s_arready;
    assign rd_ep  = 3'(s_araddr[7:4]);

    // address and data may arrive in either order; each held until the write fires
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_awaddr;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_wdata;
                wstrb_q  <= s_wstrb;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // ready only while the slot is empty, so one write at a time
    assign s_awready = !aw_have_q && !bvalid_q;
    assign s_wready  = !w_have_q && !bvalid_q;

    // write response, slverr for unmapped addresses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= uesr_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wr_hit_ep && wr_off != {4'h0, 4'hc}) ||
                        wa == uesr_pkg::OFF_ISTS || wa == uesr_pkg::OFF_IMSK
                        ? uesr_pkg::RESP_OKAY : uesr_pkg::RESP_SLVERR;
        end else if (s_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // configuration fields; hardware enforces the fixed direction per endpoint
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < uesr_pkg::NUM_EP; i++) begin
                // endpoint i+1: odd number (even index) is in
                cfg_q[i] <= '{pkt_mode: 1'b0, bus_sel: 1'b0, dir: ~i[0],
                              t_type: 2'h0, iso_per_frame_count: 2'h0};
            end
        end else if (wr_go && wr_hit_ep && wr_off == uesr_pkg::OFF_CFG) begin
            if (wstrb_q[1]) begin
                cfg_q[wr_ep].pkt_mode <= wd[uesr_pkg::B_PKT_MODE];
                cfg_q[wr_ep].bus_sel  <= wd[uesr_pkg::B_BUS_SEL];
            end
            if (wstrb_q[0]) begin
                cfg_q[wr_ep].t_type <= wd[uesr_pkg::B_TTYPE_LO +: 2];
                // reserved code 11 is refused, the old count stays
                if (wd[uesr_pkg::B_ISO_LO +: 2] != uesr_pkg::ISO_RSVD) begin
                    cfg_q[wr_ep].iso_per_frame_count <= wd[uesr_pkg::B_ISO_LO +: 2];
                end
                // direction is fixed by endpoint parity, any other value is dropped
                cfg_q[wr_ep].dir <= ~wr_ep[0];
            end
        end
    end

    // endpoint state machine driven by commands and engine events
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < uesr_pkg::NUM_EP; i++) begin
                state_q[i] <= uesr_pkg::ST_READY;
            end
        end else begin
            for (int i = 0; i < uesr_pkg::NUM_EP; i++) begin
                // restore has the last word over all other sources
                if (eng_event[i].restore) begin
                    state_q[i] <= uesr_pkg::ST_READY;
                end else if (eng_event[i].invalidate) begin
                    state_q[i] <= uesr_pkg::ST_INVALID;
                end else if (eng_event[i].halt) begin
                    state_q[i] <= uesr_pkg::ST_STALL;
                end else if ((eng_event[i].rx_err || eng_event[i].tx_tmo) &&
                             state_q[i] != uesr_pkg::ST_STALL &&
                             state_q[i] != uesr_pkg::ST_INVALID) begin
                    state_q[i] <= uesr_pkg::ST_ERROR;
                end
            end
        end
    end

    // sticky interrupt status; a new event wins over a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ists_q <= 7'h00;
            imsk_q <= 7'h00;
            irq_q  <= 1'b0;
        end else begin
            for (int i = 0; i < uesr_pkg::NUM_EP; i++) begin
                if (eng_event[i].rx_err || eng_event[i].tx_tmo) begin
                    ists_q[i] <= 1'b1;
                end else if (wr_go && wa == uesr_pkg::OFF_ISTS && wstrb_q[0] && wd[i]) begin
                    ists_q[i] <= 1'b0;
                end
            end
            if (wr_go && wa == uesr_pkg::OFF_IMSK && wstrb_q[0]) begin
                imsk_q <= wd[6:0];
            end
            // level output: any set status bit that the mask leaves visible
            irq_q <= |(ists_q & ~imsk_q);
        end
    end

    // data port strobes, only over the common bus path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwr_q <= 7'h00;
            frd_q <= 7'h00;
            fwd_q <= 16'h0000;
        end else begin
            fwr_q <= 7'h00;
            frd_q <= 7'h00;
            // direct path owns the fifo, so bus accesses are ignored then
            if (wr_go && wr_hit_ep && wr_off == uesr_pkg::OFF_DATA &&
                !cfg_q[wr_ep].bus_sel) begin
                fwr_q[wr_ep] <= 1'b1;
                fwd_q        <= wd[15:0];
            end
            if (rd_go && s_araddr[7:4] < 4'(uesr_pkg::NUM_EP) &&
                s_araddr[3:0] == uesr_pkg::OFF_DATA[3:0] &&
                !cfg_q[3'(s_araddr[7:4])].bus_sel) begin
                frd_q[3'(s_araddr[7:4])] <= 1'b1;
            end
        end
    end

    // read path: one read at a time, answer one cycle after the address
    assign s_arready = !rvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= uesr_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q  <= uesr_pkg::RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
            if (s_araddr[7:4] < 4'(uesr_pkg::NUM_EP) && s_araddr[1:0] == 2'h0) begin
                case (s_araddr[3:0])
                    uesr_pkg::OFF_CFG[3:0]: begin
                        rdata_q[uesr_pkg::B_PKT_MODE]      <= cfg_q[rd_ep].pkt_mode;
                        rdata_q[uesr_pkg::B_BUS_SEL]       <= cfg_q[rd_ep].bus_sel;
                        rdata_q[uesr_pkg::B_TOG_LO +: 2]   <= eng_status[rd_ep].toggle;
                        rdata_q[uesr_pkg::B_STATE_LO +: 3] <= state_q[rd_ep];
                        rdata_q[uesr_pkg::B_BLOCKED]       <= eng_status[rd_ep].blocked;
                        rdata_q[uesr_pkg::B_DIR]           <= cfg_q[rd_ep].dir;
                        rdata_q[uesr_pkg::B_TTYPE_LO +: 2] <= cfg_q[rd_ep].t_type;
                        rdata_q[uesr_pkg::B_ISO_LO +: 2]   <= cfg_q[rd_ep].iso_per_frame_count;
                    end
                    uesr_pkg::OFF_SIZE[3:0]: begin
                        rdata_q[10:0] <= eng_status[rd_ep].size;
                    end
                    uesr_pkg::OFF_DATA[3:0]: begin
                        rdata_q[15:0] <= fifo_rd_data[rd_ep];
                    end
                    default: begin
                        rresp_q <= uesr_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_araddr == uesr_pkg::OFF_ISTS) begin
                rdata_q[6:0] <= ists_q;
            end else if (s_araddr == uesr_pkg::OFF_IMSK) begin
                rdata_q[6:0] <= imsk_q;
            end else begin
                rresp_q <= uesr_pkg::RESP_SLVERR;
            end
        end else if (s_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // outputs straight from flip-flops
    assign s_bvalid     = bvalid_q;
    assign s_bresp      = bresp_q;
    assign s_rvalid     = rvalid_q;
    assign s_rdata      = rdata_q;
    assign s_rresp      = rresp_q;
    assign ep_cfg       = cfg_q;
    assign ep_state     = state_q;
    assign fifo_wr      = fwr_q;
    assign fifo_rd      = frd_q;
    assign fifo_wr_data = fwd_q;
    assign irq          = irq_q;

    // checks
    chk_halt_stall: assert property (@(posedge aclk) disable iff (!aresetn)
        eng_event[2].halt && !eng_event[2].restore && !eng_event[2].invalidate
        |=> state_q[2] == uesr_pkg::ST_STALL) else $error("halt did not stall");
    chk_restore_ready: assert property (@(posedge aclk) disable iff (!aresetn)
        eng_event[2].restore |=> state_q[2] == uesr_pkg::ST_READY)
        else $error("restore did not ready");
    chk_err_set: assert property (@(posedge aclk) disable iff (!aresetn)
        eng_event[2].rx_err && state_q[2] == uesr_pkg::ST_READY &&
        !eng_event[2].restore && !eng_event[2].halt && !eng_event[2].invalidate
        |=> state_q[2] == uesr_pkg::ST_ERROR) else $error("error not set");
    chk_err_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q[2] == uesr_pkg::ST_STALL && !eng_event[2].restore && !eng_event[2].invalidate
        |=> state_q[2] == uesr_pkg::ST_STALL) else $error("stall left without command");
    chk_dir_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_q[0].dir && !cfg_q[1].dir) else $error("direction not fixed");
    chk_iso_rsvd: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_q[1].iso_per_frame_count != uesr_pkg::ISO_RSVD) else $error("reserved iso");
    chk_data_upper: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_go && s_araddr == uesr_pkg::OFF_DATA |=> rdata_q[31:16] == 16'h0000)
        else $error("data upper half not zero");
    chk_bus_path: assert property (@(posedge aclk) disable iff (!aresetn)
        fwr_q[1] |-> $past(cfg_q[1].bus_sel) == 1'b0) else $error("write on direct path");
    chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        |(ists_q & ~imsk_q) |=> irq_q) else $error("irq missing");
    cov_stall: cover property (@(posedge aclk) state_q[2] == uesr_pkg::ST_STALL);
    cov_error: cover property (@(posedge aclk) state_q[2] == uesr_pkg::ST_ERROR);
    cov_fifo_wr: cover property (@(posedge aclk) |fwr_q);
    cov_irq: cover property (@(posedge aclk) irq_q);
endmodule

// ==== design/uesr_pkg.sv ====
// package for the usb endpoint status register bank: offsets, fields, reset values, carriers
// assumes an axi4-lite master on the register side and a protocol engine giving event pulses
package uesr_pkg;
    localparam int          NUM_EP       = 7;           // endpoints one to seven
    localparam logic [7:0]  EP_STRIDE    = 8'h10;       // bytes per endpoint block
    localparam logic [7:0]  OFF_CFG      = 8'h00;       // endpoint_config_state
    localparam logic [7:0]  OFF_SIZE     = 8'h04;       // endpoint_byte_count
    localparam logic [7:0]  OFF_DATA     = 8'h08;       // endpoint_data_port
    localparam logic [7:0]  OFF_ISTS     = 8'h80;       // interrupt status, one bit per ep
    localparam logic [7:0]  OFF_IMSK     = 8'h84;       // interrupt mask
    localparam int          B_PKT_MODE   = 15;
    localparam int          B_BUS_SEL    = 14;
    localparam int          B_TOG_LO     = 12;
    localparam int          B_STATE_LO   = 9;
    localparam int          B_BLOCKED    = 8;
    localparam int          B_DIR        = 7;
    localparam int          B_TTYPE_LO   = 2;
    localparam int          B_ISO_LO     = 0;
    localparam logic [2:0]  ST_READY     = 3'h0;
    localparam logic [2:0]  ST_ERROR     = 3'h2;
    localparam logic [2:0]  ST_STALL     = 3'h3;
    localparam logic [2:0]  ST_INVALID   = 3'h7;
    localparam logic [1:0]  ISO_RSVD     = 2'h3;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // writable configuration of one endpoint
    typedef struct packed {
        logic       pkt_mode;   // 1 dual buffering
        logic       bus_sel;    // 1 direct path
        logic       dir;        // 1 in
        logic [1:0] t_type;     // transfer kind
        logic [1:0] iso_per_frame_count;
    } uesr_cfg_t;

    // status reported by the protocol engine for one endpoint
    typedef struct packed {
        logic [1:0]  toggle;    // current data toggle
        logic        blocked;   // transfers not allowed
        logic [10:0] size;      // bytes of first packet
    } uesr_eng_t;

    // event pulses from engine and command register for one endpoint
    typedef struct packed {
        logic restore;          // endpoint_restore_cmd
        logic halt;             // endpoint_halt_cmd
        logic invalidate;       // endpoint made invalid
        logic rx_err;           // received data packet error
        logic tx_tmo;           // timeout after transmit
    } uesr_evt_t;
endpackage

// ==== test/uesr_regs_test.sv ====
// self-checking bench for the endpoint register bank, driven over axi4-lite
// assumes engine levels and pulses are synchronous to aclk; no separate partner model
module uesr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                      aclk, aresetn;                   // clock and sync reset
    logic [7:0]                s_awaddr, s_araddr;              // bus addresses
    logic                      s_awvalid, s_awready, s_wvalid, s_wready;
    logic [31:0]               s_wdata, s_rdata, rd_word, cfg_exp;
    logic [3:0]                s_wstrb;                         // byte strobes
    logic [1:0]                s_bresp, s_rresp, resp, iso_exp; // responses, tracked iso code
    logic                      s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
    uesr_pkg::uesr_eng_t [6:0] eng_status;                      // engine levels
    uesr_pkg::uesr_evt_t [6:0] eng_event;                       // engine pulses
    logic [6:0][15:0]          fifo_rd_data;                    // fifo head words
    uesr_pkg::uesr_cfg_t [6:0] ep_cfg;
    logic [6:0][2:0]           ep_state;
    logic [6:0]                fifo_wr, fifo_rd, wr_seen, rd_seen;
    logic [15:0]               fifo_wr_data, wr_word;
    logic                      irq;
    int                        num_errors, cmp_count;
    // event sequence on one endpoint and the state each should leave behind
    uesr_pkg::uesr_evt_t       ev_tab [10] = '{5'h02, 5'h10, 5'h01, 5'h08, 5'h02,
                                               5'h04, 5'h01, 5'h10, 5'h0a, 5'h18};
    logic [2:0]                st_tab [10] = '{3'h2, 3'h0, 3'h2, 3'h3, 3'h3,
                                               3'h7, 3'h7, 3'h0, 3'h3, 3'h0};
    logic [7:0]                bad [3] = '{8'h0c, 8'h70, 8'h88};  // unmapped offsets

    uesr_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .eng_status(eng_status), .eng_event(eng_event),
        .fifo_rd_data(fifo_rd_data), .ep_cfg(ep_cfg), .ep_state(ep_state),
        .fifo_wr(fifo_wr), .fifo_rd(fifo_rd), .fifo_wr_data(fifo_wr_data), .irq(irq));

    // free-running 100 MHz clock
    always #5 aclk = ~aclk;

    // remember which endpoints saw a fifo strobe; gated so pre-reset unknowns never stick
    always @(posedge aclk) begin
        if (aresetn) begin
            wr_seen <= wr_seen | fifo_wr;
            rd_seen <= rd_seen | fifo_rd;
            if (fifo_wr != 7'h00) begin
                wr_word <= fifo_wr_data;
            end
        end
    end

    // one comparison; case inequality so an unknown never passes
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // axi4-lite write: both halves offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
        int   n = 0;
        logic aw_ok = 1'b0;
        logic w_ok = 1'b0;
        logic b_ok = 1'b0;
        @(posedge aclk);
        s_awaddr  <= a;
        s_awvalid <= 1'b1;
        s_wdata   <= d;
        s_wstrb   <= st;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        while (!b_ok && n < 200) begin
            @(posedge aclk);
            n++;
            if (!aw_ok && s_awready) begin
                aw_ok = 1'b1;
                s_awvalid <= 1'b0;
            end
            if (!w_ok && s_wready) begin
                w_ok = 1'b1;
                s_wvalid <= 1'b0;
            end
            if (s_bvalid) begin
                b_ok = 1'b1;
                resp = s_bresp;
                s_bready <= 1'b0;
            end
        end
        chk(32'(b_ok), 32'h1);
    endtask

    // axi4-lite read; data and response taken at the edge rvalid is seen
    task automatic axi_rd(input logic [7:0] a);
        int   n = 0;
        logic r_ok = 1'b0;
        @(posedge aclk);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        while (!r_ok && n < 200) begin
            @(posedge aclk);
            n++;
            if (s_arvalid && s_arready) begin
                s_arvalid <= 1'b0;
            end
            if (s_rvalid) begin
                r_ok = 1'b1;
                rd_word = s_rdata;
                resp = s_rresp;
                s_rready <= 1'b0;
            end
        end
        chk(32'(r_ok), 32'h1);
    endtask

    // mapped accesses expect an okay response
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a);
        chk(32'(resp), 32'(uesr_pkg::RESP_OKAY));
        chk(rd_word, exp);
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
        axi_wr(a, d, st);
        chk(32'(resp), 32'(uesr_pkg::RESP_OKAY));
    endtask

    // one-cycle engine pulse; returns once the state update is visible
    task automatic pulse(input int i, input uesr_pkg::uesr_evt_t ev);
        @(posedge aclk);
        eng_event[i] <= ev;
        @(posedge aclk);
        eng_event[i] <= '0;
        @(posedge aclk);
    endtask

    function automatic logic [7:0] base(input int i);
        return 8'(i) * uesr_pkg::EP_STRIDE;
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 5000 cycles
    initial begin
        #200us;
        chk(32'h0, 32'h1);
        wrap_up();
    end

    // main sequence
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
        {s_araddr, s_arvalid, s_rready, wr_seen, rd_seen, wr_word} = '0;
        eng_event = '0;
        iso_exp = 2'h0;
        for (int i = 0; i < 7; i++) begin
            eng_status[i] = {2'(i), i[0], 11'(11'h7f9 + i)};  // last endpoint gets 0x7ff
            fifo_rd_data[i] = 16'(16'h5a50 + i);
        end
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, engine status fields and per-endpoint copies
        for (int i = 0; i < 7; i++) begin
            rd_chk(base(i), {18'h0, 2'(i), 3'h0, i[0], ~i[0], 7'h0});
            rd_chk(base(i) + uesr_pkg::OFF_SIZE, 32'(11'h7f9 + i));
            chk(32'(ep_cfg[i]), {27'h0, ~i[0], 4'h0});
        end
        $display("test reset_status done");
        // every transfer kind and iso code on an out endpoint; direction writes refused
        for (int t = 0; t < 4; t++) begin
            for (int m = 0; m < 4; m++) begin
                if (m != 3) begin
                    iso_exp = 2'(m);
                end
                cfg_exp = {16'h0, t[0], 3'b001, 3'h0, 1'b1, 1'b0, 3'h0, 2'(t), iso_exp};
                wr_ok(8'h10, {16'h0, t[0], 8'h01, 3'h0, 2'(t), 2'(m)}, 4'hf);
                rd_chk(8'h10, cfg_exp);
                chk(32'(ep_cfg[1]), 32'({t[0], 2'b00, 2'(t), iso_exp}));
            end
        end
        $display("test config_codes done");
        // path select and partial strobes on an in endpoint
        wr_ok(8'h00, 32'h0000_c00f, 4'hf);
        rd_chk(8'h00, 32'h0000_c08c);
        wr_ok(8'h00, 32'h0000_0005, 4'h1);
        rd_chk(8'h00, 32'h0000_c085);
        chk(32'(ep_cfg[0].bus_sel), 32'h1);
        $display("test path_select done");
        // data port: direct path ignores bus access, common path strobes the fifo
        wr_ok(8'h08, 32'h0000_1111, 4'hf);
        rd_chk(8'h08, 32'h0000_5a50);
        repeat (2) @(posedge aclk);
        chk(32'(wr_seen) << 8 | 32'(rd_seen), 32'h0);
        wr_ok(8'h18, 32'habcd_1234, 4'hf);
        rd_chk(8'h18, 32'h0000_5a51);
        repeat (2) @(posedge aclk);
        chk({wr_word, 1'b0, wr_seen, 1'b0, rd_seen}, 32'h1234_0202);
        $display("test data_port done");
        // endpoint state machine, including ignored errors and same-cycle events
        for (int k = 0; k < 10; k++) begin
            pulse(2, ev_tab[k]);
            chk(32'(ep_state[2]), 32'(st_tab[k]));
            rd_chk(8'h20, {18'h0, 2'h2, st_tab[k], 9'h080});
        end
        $display("test endpoint_state done");
        // interrupt: raise, mask, unmask, clear
        wr_ok(uesr_pkg::OFF_ISTS, 32'h0000_007f, 4'hf);
        wr_ok(uesr_pkg::OFF_IMSK, 32'h0, 4'hf);
        rd_chk(uesr_pkg::OFF_ISTS, 32'h0);
        chk(32'(irq), 32'h0);
        pulse(2, 5'h02);
        @(posedge aclk);
        chk(32'(irq), 32'h1);
        rd_chk(uesr_pkg::OFF_ISTS, 32'h0000_0004);
        wr_ok(uesr_pkg::OFF_IMSK, 32'h0000_0004, 4'hf);
        @(posedge aclk);
        chk(32'(irq), 32'h0);
        rd_chk(uesr_pkg::OFF_IMSK, 32'h0000_0004);
        wr_ok(uesr_pkg::OFF_IMSK, 32'h0, 4'hf);
        @(posedge aclk);
        chk(32'(irq), 32'h1);
        wr_ok(uesr_pkg::OFF_ISTS, 32'h0000_0004, 4'hf);
        @(posedge aclk);
        chk(32'(irq), 32'h0);
        rd_chk(uesr_pkg::OFF_ISTS, 32'h0);
        $display("test interrupt done");
        // unmapped offsets answer with an error and change nothing
        for (int k = 0; k < 3; k++) begin
            axi_wr(bad[k], 32'hffff_ffff, 4'hf);
            chk(32'(resp), 32'(uesr_pkg::RESP_SLVERR));
            axi_rd(bad[k]);
            chk(32'(resp), 32'(uesr_pkg::RESP_SLVERR));
        end
        rd_chk(8'h00, 32'h0000_c085);
        $display("test unmapped done");
        wrap_up();
    end
endmodule
